// file: fpsw_assertions.sv
// Port checker for the flash write control
`timescale 1ns/1ps
`default_nettype none
module fpsw_assertions
  import fpsw_pkg::*;
(
  // Clock and reset
  input wire logic                 I_CLK,
  input wire logic                 I_SYS_RST,
  input wire logic                 I_CE,
  // Watched ports
  input wire logic [7:0]           I_REG_ADDR,
  input wire logic [7:0]           I_REG_WDATA,
  input wire logic                 I_REG_WR,
  input wire fpsw_pkg::fpsw_xreq_t I_XREQ,
  input wire logic                 O_XVALID,
  input wire logic                 O_STALL,
  input wire logic                 O_EXTERNAL_DATA_RAM_WR,
  input wire logic                 O_EXTERNAL_DATA_RAM_RD,
  input wire logic                 I_IRQ_REQ,
  input wire logic                 O_IRQ_TO_CORE,
  input wire logic                 O_FLASH_ERR_RST
);
  logic [1:0] psc_q;
  logic [1:0] sup_q;
  logic [7:0] cnt_q;
  wire        wa = I_CE && I_REG_WR;
  // Shadow copies, since the checker sees no internal state
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      psc_q <= FPSW_PSC_RST[1:0];
      sup_q <= FPSW_SUP_RST;
      cnt_q <= 8'h00;
    end else if (I_CE) begin
      if (wa && I_REG_ADDR == FPSW_PSC_OFS) psc_q <= I_REG_WDATA[1:0];
      if (wa && I_REG_ADDR == FPSW_SUP_OFS) sup_q <= I_REG_WDATA[1:0];
      cnt_q <= O_STALL ? cnt_q + 8'h01 : 8'h00;
    end
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  // Flash requests are only taken while the clock enable is high
  wire go = I_CE && I_XREQ.wr && psc_q[0] && !O_STALL;
  property p_irq_hold; O_STALL |-> !O_IRQ_TO_CORE; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq not held");
  property p_irq_pass; !O_STALL |-> O_IRQ_TO_CORE == I_IRQ_REQ; endproperty
  a_irq_pass: assert property (p_irq_pass) else $error("irq not passed");
  property p_ram_rd; I_XREQ.rd && !O_STALL |-> O_EXTERNAL_DATA_RAM_RD; endproperty
  a_ram_rd: assert property (p_ram_rd) else $error("read missed ram");
  property p_to_flash; I_XREQ.wr && psc_q[0] |-> !O_EXTERNAL_DATA_RAM_WR; endproperty
  a_to_flash: assert property (p_to_flash) else $error("write hit ram");
  property p_to_ram; I_XREQ.wr && !psc_q[0] && !O_STALL |-> O_EXTERNAL_DATA_RAM_WR; endproperty
  a_to_ram: assert property (p_to_ram) else $error("write missed ram");
  property p_blocked; go && sup_q != 2'h3 |=> O_FLASH_ERR_RST && !O_STALL; endproperty
  a_blocked: assert property (p_blocked) else $error("bad supply not blocked");
  property p_no_err; go && sup_q == 2'h3 |=> !O_FLASH_ERR_RST; endproperty
  a_no_err: assert property (p_no_err) else $error("spurious error reset");
  property p_len;
    !O_STALL && $past(O_STALL) && !$past(I_SYS_RST) |-> cnt_q == FPSW_WR_CYC + 1 || cnt_q == FPSW_ER_CYC + 1;
  endproperty
  a_len: assert property (p_len) else $error("stall length wrong");
  property p_xvalid; I_CE && (I_XREQ.rd || I_XREQ.code_rd) && !O_STALL |=> O_XVALID; endproperty
  a_xvalid: assert property (p_xvalid) else $error("read not answered");
  c_erase: cover property (!O_STALL && $past(O_STALL) && cnt_q == FPSW_ER_CYC + 1);
  c_write: cover property (!O_STALL && $past(O_STALL) && cnt_q == FPSW_WR_CYC + 1);
  c_err: cover property (O_FLASH_ERR_RST);
endmodule : fpsw_assertions
`default_nettype wire

// file: fpsw_ctrl.sv
// Flash program store write and page-erase controller
// Contract
// - External-space writes store data; code-space reads return flash contents.
// - External-space reads always go to external data RAM.
// - Flash writes and erases blocked unless supply monitor enabled and selected.
// - Attempt with monitor off or deselected raises a flash-error reset.
// - Supply monitor comes up enabled and selected after reset.
// - Interrupts during an operation are held until it completes.
// - Erase-enable plus write-enable makes an external write erase the page.
// - Data byte of a page-erase write is ignored.
// - Write-enable steers one external write byte into flash.
// - Write-enable clear leaves flash untouched.
// - Erase-enable clear means no page erasure.
// - Key register needs the two unlock codes in order.
// - Wrong key order or early operation locks flash until reset.
// - Flash relocks after each completed write or erase.
// - Byte write only clears bits; only erase sets them.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module fpsw_ctrl (
  // Clock, reset, enable
  input  wire logic                        I_CLK,
  input  wire logic                        I_SYS_RST,
  input  wire logic                        I_CE,
  // Register port
  input  wire logic [7:0]                  I_REG_ADDR,
  input  wire logic [7:0]                  I_REG_WDATA,
  input  wire logic                        I_REG_WR,
  input  wire logic                        I_REG_RD,
  output logic      [7:0]                  O_REG_RDATA,
  // Core external and code space requests
  input  wire fpsw_pkg::fpsw_xreq_t        I_XREQ,
  output logic      [7:0]                  O_XDATA,
  output logic                             O_XVALID,
  output logic                             O_STALL,
  // External data RAM port
  output logic                             O_EXTERNAL_DATA_RAM_WR,
  output logic                             O_EXTERNAL_DATA_RAM_RD,
  output logic      [fpsw_pkg::FPSW_AW-1:0] O_EXTERNAL_DATA_RAM_ADDR,
  output logic      [7:0]                  O_EXTERNAL_DATA_RAM_WDATA,
  input  wire logic [7:0]                  I_EXTERNAL_DATA_RAM_RDATA,
  // Interrupt hold, flash-error reset and block interrupt
  input  wire logic                        I_IRQ_REQ,
  output logic                             O_IRQ_TO_CORE,
  output logic                             O_FLASH_ERR_RST,
  output logic                             O_IRQ
);
  import fpsw_pkg::*;

  logic [7:0]         mem_q [FPSW_DEPTH];
  logic [1:0]         psc_q;
  logic [1:0]         sup_q;
  fpsw_seq_t          seq_q;
  fpsw_seq_t          seq_d;
  logic [15:0]        cnt_q;
  logic [FPSW_AW-1:0] op_addr_q;
  logic [7:0]         op_data_q;
  logic [7:0]         xdata_q;
  logic               xvalid_q;
  logic               rdsel_q;
  logic [7:0]         rdreg_q;
  logic               ferr_q;
  logic               external_data_ram_rd_q;
  logic [3:0]         page_idx_q;
  fpsw_lock_t         lock_st;
  logic [2:0]         irq_stat;
  logic [2:0]         irq_en;

  // Register decode
  wire wr_psc  = I_REG_WR && (I_REG_ADDR == FPSW_PSC_OFS);
  wire wr_key  = I_REG_WR && (I_REG_ADDR == FPSW_KEY_OFS);
  wire wr_sup  = I_REG_WR && (I_REG_ADDR == FPSW_SUP_OFS);
  wire wr_ien  = I_REG_WR && (I_REG_ADDR == FPSW_IRQ_EN_OFS);
  wire wr_iclr = I_REG_WR && (I_REG_ADDR == FPSW_IRQ_CLR_OFS);

  // Request decode
  wire idle     = (seq_q == FPSW_SQ_IDLE);
  wire we       = psc_q[FPSW_WE_BIT];
  wire ee       = psc_q[FPSW_EE_BIT];
  wire sup_ok   = sup_q[FPSW_SUP_EN_BIT] && sup_q[FPSW_SUP_RS_BIT];
  wire flash_wr = idle && I_XREQ.wr && we;
  wire external_data_ram_wr  = idle && I_XREQ.wr && !we;
  wire op_try   = flash_wr && sup_ok;
  wire op_go    = op_try && (lock_st == FPSW_LK_OPEN);
  wire sup_fail = flash_wr && !sup_ok;
  wire op_done  = (seq_q == FPSW_SQ_DONE);
  wire cnt_end  = (cnt_q == 16'h0000);
  wire [FPSW_AW-1:0] erase_addr = {op_addr_q[FPSW_AW-1:FPSW_PGW], page_idx_q};

  fpsw_lock u_lock (
    .i_clk      (I_CLK),
    .i_rst      (I_SYS_RST),
    .i_ce       (I_CE),
    .i_key_wr   (wr_key),
    .i_key_data (I_REG_WDATA),
    .i_op_try   (op_try),
    .i_op_done  (op_done),
    .o_state    (lock_st)
  );

  fpsw_irq u_irq (
    .i_clk    (I_CLK),
    .i_rst    (I_SYS_RST),
    .i_ce     (I_CE),
    .i_event  ({op_try && !op_go, sup_fail, op_done}),
    .i_en_wr  (wr_ien),
    .i_clr_wr (wr_iclr),
    .i_wdata  (I_REG_WDATA[2:0]),
    .o_status (irq_stat),
    .o_enable (irq_en),
    .o_irq    (O_IRQ)
  );

  // Sequencer next state
  always_comb begin
    seq_d = seq_q;
    case (seq_q)
      FPSW_SQ_IDLE: begin
        if (op_go) seq_d = ee ? FPSW_SQ_ERASE : FPSW_SQ_WRITE;
      end
      FPSW_SQ_WRITE: begin
        if (cnt_end) seq_d = FPSW_SQ_DONE;
      end
      FPSW_SQ_ERASE: begin
        if (cnt_end) seq_d = FPSW_SQ_DONE;
      end
      FPSW_SQ_DONE: seq_d = FPSW_SQ_IDLE;
      default: seq_d = FPSW_SQ_IDLE;
    endcase
  end

  // Control registers; reserved bits are not stored
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      psc_q <= FPSW_PSC_RST[1:0];
      sup_q <= FPSW_SUP_RST;
    end else if (I_CE) begin
      if (wr_psc) psc_q <= I_REG_WDATA[1:0];
      if (wr_sup) sup_q <= I_REG_WDATA[1:0];
    end
  end

  // Sequencer, timer and captured operands
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      seq_q      <= FPSW_SQ_IDLE;
      cnt_q      <= 16'h0000;
      op_addr_q  <= '0;
      op_data_q  <= 8'h00;
      page_idx_q <= 4'h0;
    end else if (I_CE) begin
      seq_q <= seq_d;
      if (op_go) begin
        op_addr_q  <= I_XREQ.addr;
        op_data_q  <= I_XREQ.data;
        page_idx_q <= 4'h0;
        cnt_q      <= ee ? 16'(FPSW_ER_CYC - 1) : 16'(FPSW_WR_CYC - 1);
      end else if (!idle && !cnt_end) begin
        cnt_q      <= cnt_q - 16'h0001;
        page_idx_q <= page_idx_q + 4'h1;
      end
    end
  end

  // Flash array; erase walks one byte per cycle through the page
  always_ff @(posedge I_CLK) begin
    if (I_CE) begin
      if (seq_q == FPSW_SQ_ERASE) begin
        mem_q[erase_addr] <= FPSW_ERASED;
      end else if ((seq_q == FPSW_SQ_WRITE) && cnt_end) begin
        mem_q[op_addr_q] <= mem_q[op_addr_q] & op_data_q;
      end
    end
  end

  // Code-space reads return flash; external reads come from RAM
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      xdata_q   <= 8'h00;
      xvalid_q  <= 1'b0;
      external_data_ram_rd_q <= 1'b0;
      ferr_q    <= 1'b0;
    end else if (I_CE) begin
      xvalid_q  <= idle && (I_XREQ.code_rd || I_XREQ.rd);
      external_data_ram_rd_q <= idle && I_XREQ.rd && !I_XREQ.code_rd;
      if (idle && I_XREQ.code_rd) xdata_q <= mem_q[I_XREQ.addr];
      ferr_q    <= sup_fail;
    end
  end

  // Read data one cycle after the strobe
  wire [7:0] rd_mux =
      (I_REG_ADDR == FPSW_PSC_OFS)      ? {6'h00, psc_q} :
      (I_REG_ADDR == FPSW_KEY_OFS)      ? {6'h00, lock_st} :
      (I_REG_ADDR == FPSW_SUP_OFS)      ? {6'h00, sup_q} :
      (I_REG_ADDR == FPSW_IRQ_STAT_OFS) ? {5'h00, irq_stat} :
      (I_REG_ADDR == FPSW_IRQ_EN_OFS)   ? {5'h00, irq_en} : 8'h00;

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      rdreg_q <= 8'h00;
      rdsel_q <= 1'b0;
    end else if (I_CE) begin
      rdsel_q <= I_REG_RD;
      if (I_REG_RD) rdreg_q <= rd_mux;
    end
  end

  // Outputs
  assign O_REG_RDATA     = rdsel_q ? rdreg_q : 8'h00;
  assign O_XDATA         = external_data_ram_rd_q ? I_EXTERNAL_DATA_RAM_RDATA : xdata_q;
  assign O_XVALID        = xvalid_q;
  assign O_STALL         = !idle;
  assign O_IRQ_TO_CORE   = I_IRQ_REQ && idle;
  assign O_FLASH_ERR_RST = ferr_q;
  assign O_EXTERNAL_DATA_RAM_WR       = external_data_ram_wr;
  assign O_EXTERNAL_DATA_RAM_RD       = idle && I_XREQ.rd && !I_XREQ.code_rd;
  assign O_EXTERNAL_DATA_RAM_ADDR     = I_XREQ.addr;
  assign O_EXTERNAL_DATA_RAM_WDATA    = I_XREQ.data;
endmodule : fpsw_ctrl
`default_nettype wire

// file: fpsw_external_data_ram_model.sv
// External data RAM model on the far side
`timescale 1ns/1ps
`default_nettype none
module fpsw_external_data_ram_model (
  // Clock
  input  wire logic       i_clk,
  // RAM port
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [8:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata
);
  logic [7:0] mem [0:511];
  initial o_rdata = 8'h00;
  // Data only in the cycle after a read; toggles otherwise so stale data never matches
  always @(posedge i_clk) begin
    if (i_wr) mem[i_addr] <= i_wdata;
    o_rdata <= i_rd ? mem[i_addr] : ~o_rdata;
  end
endmodule : fpsw_external_data_ram_model
`default_nettype wire

// file: fpsw_irq.sv
// Sticky event status with enable and write-one clear
`timescale 1ns/1ps
`default_nettype none
module fpsw_irq (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  // Events and software access
  input  wire logic [2:0]  i_event,
  input  wire logic        i_en_wr,
  input  wire logic        i_clr_wr,
  input  wire logic [2:0]  i_wdata,
  // State
  output logic      [2:0]  o_status,
  output logic      [2:0]  o_enable,
  output logic             o_irq
);
  import fpsw_pkg::*;
  logic [2:0] stat_q;
  logic [2:0] en_q;
  // Set wins over a clear in the same cycle
  wire  [2:0] stat_d = (stat_q & ~({3{i_clr_wr}} & i_wdata)) | i_event;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stat_q <= FPSW_IRQ_RST;
      en_q   <= FPSW_IRQ_RST;
    end else if (i_ce) begin
      stat_q <= stat_d;
      if (i_en_wr) en_q <= i_wdata;
    end
  end
  assign o_status = stat_q;
  assign o_enable = en_q;
  assign o_irq    = |(stat_q & en_q);
endmodule : fpsw_irq
`default_nettype wire

// file: fpsw_lock.sv
// Unlock key sequence tracker
`timescale 1ns/1ps
`default_nettype none
module fpsw_lock (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_ce,
  // Key writes and operation outcome
  input  wire logic                 i_key_wr,
  input  wire logic [7:0]           i_key_data,
  input  wire logic                 i_op_try,
  input  wire logic                 i_op_done,
  // State
  output var fpsw_pkg::fpsw_lock_t  o_state
);
  import fpsw_pkg::*;
  fpsw_lock_t state_q;
  fpsw_lock_t state_d;
  always_comb begin
    state_d = state_q;
    case (state_q)
      FPSW_LK_LOCKED: begin
        if (i_op_try) state_d = FPSW_LK_DEAD;
        else if (i_key_wr) state_d = (i_key_data == FPSW_KEY1) ? FPSW_LK_FIRST : FPSW_LK_DEAD;
      end
      FPSW_LK_FIRST: begin
        if (i_op_try) state_d = FPSW_LK_DEAD;
        else if (i_key_wr) state_d = (i_key_data == FPSW_KEY2) ? FPSW_LK_OPEN : FPSW_LK_DEAD;
      end
      FPSW_LK_OPEN: begin
        if (i_key_wr) state_d = FPSW_LK_DEAD;
        else if (i_op_done) state_d = FPSW_LK_LOCKED;
      end
      default: state_d = FPSW_LK_DEAD;
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) state_q <= FPSW_LK_LOCKED;
    else if (i_ce) state_q <= state_d;
  end
  assign o_state = state_q;
endmodule : fpsw_lock
`default_nettype wire

// file: fpsw_pkg.sv
// Package: register map, field layout, timing and carrier types for the flash write control
package fpsw_pkg;
  // Register offsets on the plain register port
  localparam logic [7:0] FPSW_PSC_OFS      = 8'h8F;
  localparam logic [7:0] FPSW_KEY_OFS      = 8'hB7;
  localparam logic [7:0] FPSW_SUP_OFS      = 8'hC0;
  localparam logic [7:0] FPSW_IRQ_STAT_OFS = 8'hC1;
  localparam logic [7:0] FPSW_IRQ_EN_OFS   = 8'hC2;
  localparam logic [7:0] FPSW_IRQ_CLR_OFS  = 8'hC3;
  // Field positions
  localparam int FPSW_WE_BIT     = 0;
  localparam int FPSW_EE_BIT     = 1;
  localparam int FPSW_SUP_EN_BIT = 0;
  localparam int FPSW_SUP_RS_BIT = 1;
  localparam int FPSW_EV_DONE    = 0;
  localparam int FPSW_EV_ERR     = 1;
  localparam int FPSW_EV_LOCK    = 2;
  // Reset values
  localparam logic [7:0] FPSW_PSC_RST = 8'h00;
  localparam logic [1:0] FPSW_SUP_RST = 2'h3;
  localparam logic [2:0] FPSW_IRQ_RST = 3'h0;
  // Unlock codes
  localparam logic [7:0] FPSW_KEY1 = 8'hA5;
  localparam logic [7:0] FPSW_KEY2 = 8'hF1;
  // Flash geometry
  localparam int FPSW_AW   = 9;
  localparam int FPSW_PGW  = 4;
  localparam int FPSW_DEPTH = 512;
  localparam int FPSW_PAGE  = 16;
  localparam logic [7:0] FPSW_ERASED = 8'hFF;
  // Timing at 40 MHz
  localparam int FPSW_CLK_MHZ   = 40;
  localparam int FPSW_WR_NS     = 500;
  localparam int FPSW_WR_CYC    = (FPSW_WR_NS * FPSW_CLK_MHZ + 999) / 1000;
  localparam int FPSW_ER_CYC    = FPSW_PAGE;
  // Lock states as read from the key register
  typedef enum logic [1:0] {
    FPSW_LK_LOCKED = 2'b00,
    FPSW_LK_FIRST  = 2'b01,
    FPSW_LK_OPEN   = 2'b10,
    FPSW_LK_DEAD   = 2'b11
  } fpsw_lock_t;
  // Sequencer states, Gray along idle-write/erase-done
  typedef enum logic [1:0] {
    FPSW_SQ_IDLE  = 2'b00,
    FPSW_SQ_WRITE = 2'b01,
    FPSW_SQ_ERASE = 2'b11,
    FPSW_SQ_DONE  = 2'b10
  } fpsw_seq_t;
  // External-space request from the core
  typedef struct packed {
    logic                wr;
    logic                rd;
    logic                code_rd;
    logic [FPSW_AW-1:0]  addr;
    logic [7:0]          data;
  } fpsw_xreq_t;
endpackage : fpsw_pkg

// file: testbench.sv
// Self-checking bench for the flash write control
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fpsw_pkg::*;
  logic       clk, rst, rwr, rrd, xvalid, stall, ram_wr, ram_rd, irq_req, irq_core, err_rst, irq, e, ce;
  logic [7:0] addr, wdata, rdata, xdata, ram_wdata, ram_rdata, n;
  logic [8:0] ram_addr;
  fpsw_xreq_t xreq;
  int         n_errors, total_checks, cyc;
  fpsw_ctrl u_fpsw_ctrl (.I_CLK(clk), .I_SYS_RST(rst), .I_CE(ce), .I_REG_ADDR(addr),
    .I_REG_WDATA(wdata), .I_REG_WR(rwr), .I_REG_RD(rrd), .O_REG_RDATA(rdata), .I_XREQ(xreq),
    .O_XDATA(xdata), .O_XVALID(xvalid), .O_STALL(stall), .O_EXTERNAL_DATA_RAM_WR(ram_wr), .O_EXTERNAL_DATA_RAM_RD(ram_rd),
    .O_EXTERNAL_DATA_RAM_ADDR(ram_addr), .O_EXTERNAL_DATA_RAM_WDATA(ram_wdata), .I_EXTERNAL_DATA_RAM_RDATA(ram_rdata),
    .I_IRQ_REQ(irq_req), .O_IRQ_TO_CORE(irq_core), .O_FLASH_ERR_RST(err_rst), .O_IRQ(irq));
  fpsw_external_data_ram_model u_fpsw_external_data_ram_model (.i_clk(clk), .i_wr(ram_wr), .i_rd(ram_rd), .i_addr(ram_addr),
    .i_wdata(ram_wdata), .o_rdata(ram_rdata));
  always #12.5 clk = ~clk;
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] x);
    total_checks++;
    if (s !== x) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, s, x);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    addr <= a;
    rrd <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
    #1 chk(rdata, x);
  endtask : rd
  task automatic unlock;
    wr(FPSW_KEY_OFS, FPSW_KEY1);
    wr(FPSW_KEY_OFS, FPSW_KEY2);
  endtask : unlock
  // Returns stall cycles and the error pulse seen in the cycle after the request
  task automatic xw(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    xreq.wr <= 1'b1;
    xreq.addr <= a;
    xreq.data <= d;
    @(posedge clk);
    xreq.wr <= 1'b0;
    #1 e = err_rst;
    n = 8'h00;
    while (stall === 1'b1 && n < 8'd100) begin
      @(posedge clk);
      #1 n++;
    end
  endtask : xw
  task automatic xr(input logic c, input logic [8:0] a, input logic [7:0] x);
    @(posedge clk);
    xreq.code_rd <= c;
    xreq.rd <= !c;
    xreq.addr <= a;
    @(posedge clk);
    xreq.code_rd <= 1'b0;
    xreq.rd <= 1'b0;
    #1 chk(xdata, x);
    chk(8'(xvalid), 8'h01);
  endtask : xr
  task automatic ci(input logic x);
    repeat (2) @(posedge clk);
    #1 chk(8'(irq), 8'(x));
  endtask : ci
  initial begin
    {clk, rwr, rrd, addr, wdata, xreq, n_errors, total_checks, cyc} = '0;
    rst = 1'b1;
    ce = 1'b1;
    irq_req = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(FPSW_PSC_OFS, 8'h00);
    rd(FPSW_SUP_OFS, 8'h03);
    rd(FPSW_KEY_OFS, 8'h00);
    rd(8'h55, 8'h00);
    $display("reset test done");
    wr(FPSW_PSC_OFS, 8'h03);
    unlock();
    rd(FPSW_KEY_OFS, 8'h02);
    xw(9'h013, 8'h00);
    chk(n, 8'(FPSW_ER_CYC + 1));
    chk(8'(irq_core), 8'h01);
    rd(FPSW_KEY_OFS, 8'h00);
    xr(1'b1, 9'h010, FPSW_ERASED);
    xr(1'b1, 9'h013, FPSW_ERASED);
    $display("erase test done");
    wr(FPSW_PSC_OFS, 8'h01);
    unlock();
    xw(9'h012, 8'h5A);
    chk(n, 8'(FPSW_WR_CYC + 1));
    xr(1'b1, 9'h012, 8'h5A);
    unlock();
    xw(9'h012, 8'hF0);
    xr(1'b1, 9'h012, 8'h50);
    unlock();
    xw(9'h013, 8'h0F);
    xr(1'b1, 9'h013, 8'h0F);
    xr(1'b1, 9'h012, 8'h50);
    $display("write test done");
    wr(FPSW_PSC_OFS, 8'h00);
    xw(9'h012, 8'h3C);
    chk(n, 8'h00);
    xr(1'b1, 9'h012, 8'h50);
    xr(1'b0, 9'h012, 8'h3C);
    wr(FPSW_PSC_OFS, 8'h01);
    xr(1'b0, 9'h012, 8'h3C);
    @(posedge clk);
    irq_req <= 1'b0;
    $display("ram test done");
    rd(FPSW_IRQ_STAT_OFS, 8'h01);
    wr(FPSW_IRQ_EN_OFS, 8'h01);
    ci(1'b1);
    wr(FPSW_IRQ_EN_OFS, 8'h00);
    ci(1'b0);
    wr(FPSW_IRQ_EN_OFS, 8'h01);
    wr(FPSW_IRQ_CLR_OFS, 8'h07);
    rd(FPSW_IRQ_STAT_OFS, 8'h00);
    ci(1'b0);
    $display("interrupt test done");
    // Write with the enable low must not land
    @(posedge clk);
    ce <= 1'b0;
    wr(FPSW_PSC_OFS, 8'h03);
    ce <= 1'b1;
    rd(FPSW_PSC_OFS, 8'h01);
    $display("enable test done");
    unlock();
    for (int s = 0; s < 3; s++) begin
      wr(FPSW_SUP_OFS, 8'(s));
      xw(9'h020, 8'h00);
      chk(8'(e), 8'h01);
      chk(n, 8'h00);
    end
    rd(FPSW_KEY_OFS, 8'h02);
    wr(FPSW_SUP_OFS, 8'h03);
    rd(FPSW_IRQ_STAT_OFS, 8'h02);
    wr(FPSW_IRQ_CLR_OFS, 8'h07);
    $display("supply test done");
    wr(FPSW_KEY_OFS, 8'h00);
    rd(FPSW_KEY_OFS, 8'h03);
    unlock();
    rd(FPSW_KEY_OFS, 8'h03);
    xw(9'h020, 8'h00);
    chk(n, 8'h00);
    chk(8'(e), 8'h00);
    rd(FPSW_IRQ_STAT_OFS, 8'h04);
    $display("lock test done");
    // Second reset, then an attempt before any unlock
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(FPSW_SUP_OFS, 8'h03);
    rd(FPSW_KEY_OFS, 8'h00);
    wr(FPSW_PSC_OFS, 8'h01);
    xw(9'h020, 8'h00);
    chk(n, 8'h00);
    rd(FPSW_KEY_OFS, 8'h03);
    $display("early attempt test done");
    print_verdict();
  end
endmodule : testbench
bind fpsw_ctrl fpsw_assertions u_fpsw_assertions (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_CE(I_CE),
  .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA), .I_REG_WR(I_REG_WR), .I_XREQ(I_XREQ),
  .O_XVALID(O_XVALID), .O_STALL(O_STALL), .O_EXTERNAL_DATA_RAM_WR(O_EXTERNAL_DATA_RAM_WR), .O_EXTERNAL_DATA_RAM_RD(O_EXTERNAL_DATA_RAM_RD),
  .I_IRQ_REQ(I_IRQ_REQ), .O_IRQ_TO_CORE(O_IRQ_TO_CORE), .O_FLASH_ERR_RST(O_FLASH_ERR_RST));
`default_nettype wire
